/* File: common/switch_mode_consts.svh */
// Constants for the switch mode supervisor: offsets, field positions, timing
`ifndef SWITCH_MODE_CONSTS_SVH
`define SWITCH_MODE_CONSTS_SVH

`define CLK_FREQ_HZ 100000000
`define WDOG_TIMEOUT_MS 310
`define IDLE_TIMEOUT_MS 250
`define WDOG_CYCLES ((`WDOG_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000)))
`define IDLE_CYCLES ((`IDLE_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000)))

// Register word offsets (byte address = 4 * index)
`define ADDR_GCR 4'h0
`define ADDR_PWR0 4'h1
`define ADDR_PWR1 4'h2
`define ADDR_STAT 4'h3
`define ADDR_FAULT0 4'h4
`define ADDR_FAULT1 4'h5
`define ADDR_WORD 4'h6
`define ADDR_FCFG 4'h7

// Global config fields
`define GCR_WATCHDOG_DISABLE_BIT 4
`define GCR_VDDFAIL_EN 0
`define GCR_OV_EN 1
`define GCR_PWM_EN0 7
`define GCR_PWM_EN1 8
`define GCR_DIR_DIS0 2
`define GCR_DIR_DIS1 3
`define GCR_POR 9
`define GCR_GANGED 10
`define GCR_RESET 16'h0002

// Pulse width fields
`define PWR_ON_BIT 8
`define PWR_DUTY_HI 7
`define PWR_RESET 16'h0000

// Serial word fields
`define WORD_TOGGLE 15

// Fault detail fields, per channel
`define FLT_OC 0
`define FLT_OT 1
`define FLT_SC 2
`define FLT_UV 3
`define FLT_OV 4
`define FLT_SHV 5
`define FLT_OLOFF 6
`define FLT_OLON 7
`define FLT_CLK 8
`define FLT_W 9

// Optional fault enables register
`define FCFG_SHV_EN 0
`define FCFG_OLOFF_EN 1
`define FCFG_OLON_EN 2
`define FCFG_CLK_EN 3
`define FCFG_RESET 16'h0008

`endif

/* File: common/switch_mode_pkg.sv */
// Types for the switch mode supervisor
package switch_mode_pkg;
    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_FAILSAFE,
        MODE_FAULT
    } op_mode_t;
endpackage : switch_mode_pkg

/* File: hdl/switch_mode_supervisor.sv */
// Operating mode supervisor with Avalon-MM register access
`timescale 1ns/1ns
`include "switch_mode_consts.svh"

// Summary of operation
// R1 - Channel target on: input and not disabled, or on-bit with duty or no modulation
// R2 - Duty value is the low eight bits of the pulse width register
// R3 - Rising wake pin with supply, or rising direct input, enters Normal
// R4 - Controller toggles the watchdog bit within each watchdog period unless disabled
// R5 - Input activity flag clears after input idle longer than the idle timeout
// R6 - Sleep when both activity flags low and wake pin low
// R7 - Wake pin low or Fail-safe: channels follow direct inputs only
// R8 - Wake term is wake pin OR either activity flag; mode from three terms
// R9 - Fail-safe on supply loss when enabled, or watchdog timeout when not disabled
// R10 - Fault on overcurrent, overtemperature, short, undervoltage, or enabled overvoltage
// R11 - Sleep, Normal, Fail-safe, Fault chosen from wake, fail-safe and fault terms
// R12 - Watchdog disable sits at bit D4 of the global config register
// R13 - Sleep after power-up; channels and serial off; registers held at defaults
// R14 - Entering Fail-safe: output low, delatch, reset registers but two flags, block access
// R15 - Watchdog starts on rising wake pin and watches first bit of each word
// R16 - Leave Fail-safe: word with D15 set, then second word within period
// R17 - Back to Normal: output high, reset registers keeping flags and latched fault bits
// R18 - Optional faults also raise Fault: short to supply, open load, clock fail
// R19 - Fault status pin is real time; sticky bits stay until read
// R20 - Affected channel off on fault except open load, clock fail, short to supply
// R21 - Read clears a fault bit only if cause gone and not latched
// R22 - Latchable faults turn channel off, pull status low, set the bit
// R23 - Fault during Fail-safe keeps registers reset and direct-input control; after supply loss, writes in Fault still change the registers
// R24 - Watchdog and idle timeouts are counters restarted on toggle or activity
module switch_mode_supervisor
    import switch_mode_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES_P = `WDOG_CYCLES,
    parameter int unsigned IDLE_CYCLES_P = `IDLE_CYCLES
) (
    input wire logic clk_i, // System clock 100 MHz
    input wire logic nrst_i, // Synchronous reset, active low
    input wire logic [3:0] address_i, // Avalon word address
    input wire logic read_i, // Avalon read
    input wire logic write_i, // Avalon write
    input wire logic [31:0] writedata_i, // Avalon write data
    output logic [31:0] readdata_o, // Avalon read data
    output logic waitrequest_o, // Avalon wait request
    input wire logic wake_hold_pin_i, // Wake hold pin level
    input wire logic [1:0] direct_in_i, // Direct input pins
    input wire logic logic_supply_ok_i, // Logic supply present
    input wire logic pwm_duty_tick_i, // PWM phase step enable
    input wire logic [1:0] overcurrent_fault_i, // Overcurrent per channel
    input wire logic [1:0] overtemperature_fault_i, // Overtemperature per channel
    input wire logic [1:0] severe_short_fault_i, // Severe short per channel
    input wire logic undervoltage_fault_i, // Undervoltage
    input wire logic overvoltage_fault_i, // Overvoltage
    input wire logic [1:0] short_supply_fault_i, // Off-state short to supply
    input wire logic [1:0] open_off_fault_i, // Open load in off state
    input wire logic [1:0] open_on_fault_i, // Open load in on state
    input wire logic clock_fail_i, // External clock failure
    input wire logic [1:0] latched_i, // Channel latched by retry logic
    output logic [1:0] channel_on_o, // Channel drive
    output logic failsafe_out_n_o, // Fail-safe output, active low
    output logic fault_status_n_o, // Fault status, active low
    output logic normal_mode_flag_o, // Normal mode indicator
    output logic delatch_o, // Pulse delatching latched faults
    output op_mode_t mode_o // Current mode
);

    op_mode_t mode_reg;
    logic [15:0] global_config_register;
    logic [15:0] pulse_width_register [2];
    logic [15:0] fault_cfg_reg;
    logic [`FLT_W-1:0] fault_detail_register [2];
    logic [1:0] in_prev_reg;
    logic [1:0] activity_reg;
    logic [31:0] idle_cnt_reg [2];
    logic [31:0] wdog_cnt_reg;
    logic wdog_run_reg;
    logic wdog_expired_reg;
    logic toggle_last_reg;
    logic wake_prev_reg;
    logic exit_armed_reg;
    logic access_ok_reg;
    logic vdd_lost_reg;
    logic [7:0] pwm_phase_reg;
    logic wake_term;
    logic failsafe_term;
    logic fault_term;
    logic [1:0] opt_fault;
    logic [1:0] off_fault;
    logic [1:0] target_on;
    logic [`FLT_W-1:0] cause [2];
    logic wr_word;
    logic wake_rise;
    logic [1:0] in_rise;
    logic enter_fs;
    logic enter_nm;
    logic reg_access;
    logic rd_valid_reg;
    logic rd_take;

    // Register access gated in Sleep and Fail-safe
    assign reg_access = (mode_reg == MODE_NORMAL || mode_reg == MODE_FAULT) && access_ok_reg; // R13 R14 R23
    // One wait state on reads so that read data comes from a flop
    assign rd_take = read_i && !rd_valid_reg;
    assign waitrequest_o = rd_take;
    assign wr_word = write_i && logic_supply_ok_i && mode_reg != MODE_SLEEP && address_i == `ADDR_WORD;
    assign wake_rise = wake_hold_pin_i && !wake_prev_reg;
    assign in_rise = direct_in_i & ~in_prev_reg;

    // Mode terms
    assign wake_term = wake_hold_pin_i | activity_reg[0] | activity_reg[1]; // R8
    assign failsafe_term = vdd_lost_reg
        || (wdog_expired_reg && !global_config_register[`GCR_WATCHDOG_DISABLE_BIT]); // R9 R12
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            opt_fault[c] = (short_supply_fault_i[c] && fault_cfg_reg[`FCFG_SHV_EN])
                || (open_off_fault_i[c] && fault_cfg_reg[`FCFG_OLOFF_EN])
                || (open_on_fault_i[c] && fault_cfg_reg[`FCFG_OLON_EN]); // R18
            off_fault[c] = overcurrent_fault_i[c] || overtemperature_fault_i[c] || severe_short_fault_i[c]
                || undervoltage_fault_i
                || (overvoltage_fault_i && global_config_register[`GCR_OV_EN]); // R20 R22
            cause[c] = '0;
            cause[c][`FLT_OC] = overcurrent_fault_i[c];
            cause[c][`FLT_OT] = overtemperature_fault_i[c];
            cause[c][`FLT_SC] = severe_short_fault_i[c];
            cause[c][`FLT_UV] = undervoltage_fault_i;
            cause[c][`FLT_OV] = overvoltage_fault_i && global_config_register[`GCR_OV_EN];
            cause[c][`FLT_SHV] = short_supply_fault_i[c] && fault_cfg_reg[`FCFG_SHV_EN];
            cause[c][`FLT_OLOFF] = open_off_fault_i[c] && fault_cfg_reg[`FCFG_OLOFF_EN];
            cause[c][`FLT_OLON] = open_on_fault_i[c] && fault_cfg_reg[`FCFG_OLON_EN];
            cause[c][`FLT_CLK] = clock_fail_i && fault_cfg_reg[`FCFG_CLK_EN];
        end
    end
    assign fault_term = |off_fault || |opt_fault
        || (clock_fail_i && fault_cfg_reg[`FCFG_CLK_EN]); // R10 R18
    assign fault_status_n_o = !fault_term; // R19
    assign normal_mode_flag_o = (mode_reg == MODE_NORMAL);
    assign failsafe_out_n_o = !(mode_reg == MODE_FAILSAFE || (mode_reg == MODE_FAULT && failsafe_term)); // R14 R17
    assign mode_o = mode_reg;
    assign enter_fs = failsafe_term && mode_reg == MODE_NORMAL;
    assign enter_nm = mode_reg == MODE_FAILSAFE && !failsafe_term;
    assign delatch_o = enter_fs; // R14

    // Target on-state per channel
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            logic dir_dis;
            logic on_bit;
            logic pwm_en;
            logic duty;
            dir_dis = global_config_register[`GCR_DIR_DIS0 + c];
            on_bit = pulse_width_register[c][`PWR_ON_BIT];
            pwm_en = global_config_register[`GCR_PWM_EN0 + c];
            duty = pwm_phase_reg <= pulse_width_register[c][`PWR_DUTY_HI:0]; // R2
            if (!wake_hold_pin_i || mode_reg == MODE_FAILSAFE || failsafe_term) begin
                target_on[c] = direct_in_i[c]; // R7 R23
            end else begin
                target_on[c] = (direct_in_i[c] && !dir_dis) || (on_bit && duty && pwm_en)
                    || (on_bit && !pwm_en); // R1
            end
        end
    end

    // Channel drive registered; off in Sleep and for turning-off faults
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            channel_on_o <= 2'h0;
        end else if (mode_reg == MODE_SLEEP) begin
            channel_on_o <= 2'h0; // R11 R13
        end else begin
            channel_on_o <= target_on & ~off_fault; // R11 R20
        end
    end

    // Mode selection
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mode_reg <= MODE_SLEEP; // R13
        end else if (mode_reg == MODE_SLEEP) begin
            if ((wake_rise && logic_supply_ok_i) || |in_rise) begin
                mode_reg <= MODE_NORMAL; // R3
            end
        end else if (!wake_term) begin
            mode_reg <= MODE_SLEEP; // R6 R11
        end else if (fault_term) begin
            mode_reg <= MODE_FAULT; // R11
        end else if (failsafe_term) begin
            mode_reg <= MODE_FAILSAFE; // R11
        end else begin
            mode_reg <= MODE_NORMAL; // R11
        end
    end

    // Input activity flags with idle timeout
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            in_prev_reg <= 2'h0;
            activity_reg <= 2'h0;
            idle_cnt_reg[0] <= '0;
            idle_cnt_reg[1] <= '0;
        end else begin
            in_prev_reg <= direct_in_i;
            for (int c = 0; c < 2; c++) begin
                if (in_rise[c]) begin
                    activity_reg[c] <= 1'b1;
                    idle_cnt_reg[c] <= '0; // R24
                end else if (!direct_in_i[c] && activity_reg[c]) begin
                    if (idle_cnt_reg[c] >= IDLE_CYCLES_P - 1) begin
                        activity_reg[c] <= 1'b0; // R5
                    end else begin
                        idle_cnt_reg[c] <= idle_cnt_reg[c] + 32'h1; // R24
                    end
                end else begin
                    idle_cnt_reg[c] <= '0;
                end
            end
        end
    end

    // Serial watchdog
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wake_prev_reg <= 1'b0;
            wdog_run_reg <= 1'b0;
            wdog_cnt_reg <= '0;
            wdog_expired_reg <= 1'b0;
            toggle_last_reg <= 1'b0;
            exit_armed_reg <= 1'b0;
            access_ok_reg <= 1'b1;
        end else begin
            wake_prev_reg <= wake_hold_pin_i;
            if (wake_rise && logic_supply_ok_i) begin
                wdog_run_reg <= 1'b1; // R15
                wdog_cnt_reg <= '0;
            end else if (!wake_hold_pin_i || global_config_register[`GCR_WATCHDOG_DISABLE_BIT]) begin
                wdog_cnt_reg <= '0; // R15
            end else if (mode_reg == MODE_FAILSAFE || (mode_reg == MODE_FAULT && wdog_expired_reg)) begin
                if (wr_word && writedata_i[`WORD_TOGGLE] && !exit_armed_reg) begin
                    exit_armed_reg <= 1'b1; // R16
                    wdog_cnt_reg <= '0;
                end else if (wr_word && exit_armed_reg) begin
                    exit_armed_reg <= 1'b0;
                    wdog_expired_reg <= 1'b0; // R16
                    access_ok_reg <= 1'b1;
                    toggle_last_reg <= writedata_i[`WORD_TOGGLE];
                    wdog_cnt_reg <= '0;
                end else if (exit_armed_reg) begin
                    if (wdog_cnt_reg >= WDOG_CYCLES_P - 1) begin
                        exit_armed_reg <= 1'b0; // R16
                    end else begin
                        wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
                    end
                end
            end else if (wdog_run_reg && mode_reg != MODE_SLEEP) begin
                if (wr_word && writedata_i[`WORD_TOGGLE] != toggle_last_reg) begin
                    toggle_last_reg <= writedata_i[`WORD_TOGGLE];
                    wdog_cnt_reg <= '0; // R24
                end else if (wdog_cnt_reg >= WDOG_CYCLES_P - 1) begin
                    wdog_expired_reg <= 1'b1; // R9 R15
                    access_ok_reg <= 1'b0; // R14
                end else begin
                    wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
                end
            end
        end
    end

    // Supply loss kept with its enable, since Fail-safe entry clears the enable bit
    always_ff @(posedge clk_i) begin
        if (!nrst_i || enter_nm || mode_reg == MODE_SLEEP) begin
            vdd_lost_reg <= 1'b0;
        end else if (!logic_supply_ok_i && global_config_register[`GCR_VDDFAIL_EN]) begin
            vdd_lost_reg <= 1'b1; // R9
        end else if (wr_word && exit_armed_reg) begin
            vdd_lost_reg <= 1'b0; // R16
        end
    end

    // PWM phase counter
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pwm_phase_reg <= 8'h00;
        end else if (pwm_duty_tick_i) begin
            pwm_phase_reg <= pwm_phase_reg + 8'h01;
        end
    end

    // Configuration registers; cleared in Sleep, on Fail-safe entry, in Fail-safe and on its exit to Normal
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            global_config_register <= `GCR_RESET;
            pulse_width_register[0] <= `PWR_RESET;
            pulse_width_register[1] <= `PWR_RESET;
            fault_cfg_reg <= `FCFG_RESET;
        end else if (mode_reg == MODE_SLEEP || enter_fs || mode_reg == MODE_FAILSAFE || enter_nm) begin
            global_config_register <= `GCR_RESET | (global_config_register
                & ((16'h0001 << `GCR_POR) | (16'h0001 << `GCR_GANGED))); // R13 R14 R17 R23
            pulse_width_register[0] <= `PWR_RESET;
            pulse_width_register[1] <= `PWR_RESET;
            fault_cfg_reg <= `FCFG_RESET;
        end else if (write_i && reg_access) begin
            case (address_i)
                `ADDR_GCR: global_config_register <= writedata_i[15:0]; // R12
                `ADDR_PWR0: pulse_width_register[0] <= writedata_i[15:0];
                `ADDR_PWR1: pulse_width_register[1] <= writedata_i[15:0];
                `ADDR_FCFG: fault_cfg_reg <= writedata_i[15:0];
                default: ;
            endcase
        end
    end

    // Sticky fault bits; set wins over read clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            fault_detail_register[0] <= '0;
            fault_detail_register[1] <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                logic [`FLT_W-1:0] keep;
                keep = fault_detail_register[c];
                if (mode_reg == MODE_SLEEP || enter_fs || enter_nm) begin
                    keep = latched_i[c] && !enter_fs ? keep : '0; // R14 R17
                end else if (rd_take && reg_access
                        && (address_i == `ADDR_FAULT0 + 4'(c) || address_i == `ADDR_STAT)
                        && !latched_i[c]) begin
                    keep = keep & cause[c]; // R21
                end
                fault_detail_register[c] <= keep | cause[c]; // R19 R22
            end
        end
    end

    // Read wait state: data loaded first, request accepted on the next edge
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_take;
        end
    end

    // Read data
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            readdata_o <= 32'h0;
        end else if (rd_take) begin
            if (!reg_access) begin
                readdata_o <= 32'h0;
            end else begin
                case (address_i)
                    `ADDR_GCR: readdata_o <= {16'h0, global_config_register};
                    `ADDR_PWR0: readdata_o <= {16'h0, pulse_width_register[0]};
                    `ADDR_PWR1: readdata_o <= {16'h0, pulse_width_register[1]};
                    `ADDR_STAT: readdata_o <= {24'h0, channel_on_o, fault_term, failsafe_term,
                        mode_reg, |fault_detail_register[1], |fault_detail_register[0]};
                    `ADDR_FAULT0: readdata_o <= {23'h0, fault_detail_register[0]};
                    `ADDR_FAULT1: readdata_o <= {23'h0, fault_detail_register[1]};
                    `ADDR_FCFG: readdata_o <= {16'h0, fault_cfg_reg};
                    default: readdata_o <= 32'h0;
                endcase
            end
        end
    end

    // Assertions
    sequence s_fs_clear;
        mode_reg == MODE_FAILSAFE && !failsafe_term && wake_term && !fault_term;
    endsequence

    a_sleep_channels_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
        mode_reg == MODE_SLEEP |=> channel_on_o == 2'h0) else $error("channel on in sleep");
    a_fault_pin_live: assert property (@(posedge clk_i) disable iff (!nrst_i) // R19
        (|overcurrent_fault_i) || (|overtemperature_fault_i) || (|severe_short_fault_i) || undervoltage_fault_i
        |-> !fault_status_n_o) else $error("fault pin high during fault");
    a_wake_to_normal: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
        mode_reg == MODE_SLEEP && |in_rise |=> mode_reg == MODE_NORMAL) else $error("no wake");
    a_sleep_entry: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
        mode_reg != MODE_SLEEP && !wake_term |=> mode_reg == MODE_SLEEP) else $error("no sleep");
    a_fault_mode: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
        mode_reg != MODE_SLEEP && wake_term && fault_term |=> mode_reg == MODE_FAULT) else $error("no fault");
    a_failsafe_pin: assert property (@(posedge clk_i) disable iff (!nrst_i) // R14
        mode_reg == MODE_FAILSAFE |-> !failsafe_out_n_o) else $error("fail-safe pin high");
    a_wd_disable: assert property (@(posedge clk_i) disable iff (!nrst_i) // R12
        global_config_register[`GCR_WATCHDOG_DISABLE_BIT] && $stable(global_config_register)
        |=> $stable(wdog_cnt_reg) || wdog_cnt_reg == '0) else $error("watchdog counting while disabled");
    a_sticky_set: assert property (@(posedge clk_i) disable iff (!nrst_i) // R22
        overcurrent_fault_i[0] |=> fault_detail_register[0][`FLT_OC]) else $error("sticky not set");
    a_fault_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // R20
        overcurrent_fault_i[0] |=> !channel_on_o[0]) else $error("channel not off on fault");
    a_vdd_loss: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
        mode_reg == MODE_NORMAL && !logic_supply_ok_i && global_config_register[`GCR_VDDFAIL_EN]
        |=> failsafe_term) else $error("supply loss ignored");
    a_fs_to_normal: assert property (@(posedge clk_i) disable iff (!nrst_i) // R16 R17
        s_fs_clear |=> mode_reg == MODE_NORMAL) else $error("fail-safe not left");

endmodule : switch_mode_supervisor

/* File: testbench/mcu_model.sv */
// Controller model driving the wake hold pin and the direct inputs
`timescale 1ns/1ns
module mcu_model (
    input wire logic clk_i, // System clock
    output logic wake_hold_pin_o, // Wake hold pin level
    output logic [1:0] direct_in_o // Direct input pins
);
    initial begin
        wake_hold_pin_o = 1'b0;
        direct_in_o = 2'b00;
    end

    // Pins change just after a rising edge
    task pins(input logic w, input logic [1:0] d);
        @(posedge clk_i);
        wake_hold_pin_o <= w;
        direct_in_o <= d;
    endtask : pins
endmodule : mcu_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the switch mode supervisor
`timescale 1ns/1ns
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_top;
    import switch_mode_pkg::*;
    logic clk_i = 1'b0, nrst_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
    logic [3:0] address_i = 4'h0;
    logic [31:0] writedata_i = 32'h0, readdata_o, rd;
    logic waitrequest_o, wake, failsafe_out_n_o, fault_status_n_o, normal_mode_flag_o, delatch_o;
    logic [1:0] din, channel_on_o, oc = 2'h0, ot = 2'h0, sc = 2'h0, sh = 2'h0, oo = 2'h0, on_ = 2'h0;
    logic uv = 1'b0, ov = 1'b0, ck = 1'b0, tick = 1'b0, sup = 1'b1;
    logic [1:0] lat = 2'h0;
    op_mode_t mode_o;
    int err_count = 0, comparisons = 0, dl_cnt = 0;

    initial forever #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (delatch_o === 1'b1) dl_cnt <= dl_cnt + 1;
    end

    mcu_model i_mcu (.clk_i(clk_i), .wake_hold_pin_o(wake), .direct_in_o(din));

    switch_mode_supervisor #(.WDOG_CYCLES_P(50), .IDLE_CYCLES_P(40)) i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .wake_hold_pin_i(wake), .direct_in_i(din), .logic_supply_ok_i(sup), .pwm_duty_tick_i(tick),
        .overcurrent_fault_i(oc), .overtemperature_fault_i(ot), .severe_short_fault_i(sc),
        .undervoltage_fault_i(uv), .overvoltage_fault_i(ov), .short_supply_fault_i(sh),
        .open_off_fault_i(oo), .open_on_fault_i(on_), .clock_fail_i(ck), .latched_i(lat),
        .channel_on_o(channel_on_o), .failsafe_out_n_o(failsafe_out_n_o),
        .fault_status_n_o(fault_status_n_o), .normal_mode_flag_o(normal_mode_flag_o),
        .delatch_o(delatch_o), .mode_o(mode_o));

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= 1'b1;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) @(posedge clk_i);
        write_i <= 1'b0;
    endtask : wr

    task rdr(input logic [3:0] a);
        @(posedge clk_i);
        address_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) @(posedge clk_i);
        rd = readdata_o;
        read_i <= 1'b0;
    endtask : rdr

    // Wait up to n cycles for a mode, then compare
    task wm(input op_mode_t m, input int n);
        int i;
        for (i = 0; i < n && mode_o !== m; i++) @(negedge clk_i);
        `CHK("mode", m, mode_o)
    endtask : wm

    task cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task finish_test;
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin
        #50000;
        err_count++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        cyc(2);
        `CHK("sleep", MODE_SLEEP, mode_o)
        `CHK("ch off", 2'b00, channel_on_o)
        rdr(4'h0);
        `CHK("sleep rd", 32'h0, rd)
        $display("test sleep done");
        i_mcu.pins(1'b1, 2'b00);
        wm(MODE_NORMAL, 5);
        `CHK("nm flag", 1'b1, normal_mode_flag_o)
        wm(MODE_FAILSAFE, 70);
        `CHK("fso", 1'b0, failsafe_out_n_o)
        rdr(4'h0);
        `CHK("fs rd", 32'h0, rd)
        i_mcu.pins(1'b1, 2'b01);
        cyc(3);
        `CHK("fs ch", 2'b01, channel_on_o)
        i_mcu.pins(1'b1, 2'b00);
        cyc(3);
        `CHK("fs ch", 2'b00, channel_on_o)
        wr(4'h6, 32'h8000);
        wr(4'h6, 32'h0000);
        wm(MODE_NORMAL, 5);
        `CHK("fso", 1'b1, failsafe_out_n_o)
        wr(4'h0, 32'h0012);
        rdr(4'h0);
        `CHK("watchdog_disable_bit", 1'b1, rd[4])
        cyc(80);
        wm(MODE_NORMAL, 1);
        wr(4'h0, 32'h0013);
        @(posedge clk_i);
        sup <= 1'b0;
        wm(MODE_FAILSAFE, 5);
        `CHK("vdd fso", 1'b0, failsafe_out_n_o)
        @(posedge clk_i);
        sup <= 1'b1;
        wr(4'h6, 32'h8000);
        wr(4'h6, 32'h0000);
        wm(MODE_NORMAL, 5);
        wr(4'h0, 32'h0012);
        $display("test watchdog done");
        wr(4'h1, 32'h0100);
        cyc(3);
        `CHK("on bit", 2'b01, channel_on_o)
        rdr(4'h1);
        `CHK("pw rd", 32'h0100, rd)
        wr(4'h0, 32'h0092);
        wr(4'h1, 32'h01FF);
        cyc(3);
        `CHK("pwm full", 2'b01, channel_on_o)
        wr(4'h1, 32'h00FF);
        cyc(3);
        `CHK("pwm off", 2'b00, channel_on_o)
        wr(4'h1, 32'h0100);
        @(posedge clk_i);
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        cyc(3);
        `CHK("duty 0", 2'b00, channel_on_o)
        wr(4'h1, 32'h0101);
        cyc(3);
        `CHK("duty 1", 2'b01, channel_on_o)
        wr(4'h0, 32'h0012);
        wr(4'h1, 32'h0100);
        $display("test channel done");
        @(posedge clk_i);
        oc <= 2'b01;
        wm(MODE_FAULT, 5);
        `CHK("fsb", 1'b0, fault_status_n_o)
        `CHK("oc off", 2'b00, channel_on_o)
        @(posedge clk_i);
        oc <= 2'b00;
        wm(MODE_NORMAL, 5);
        `CHK("fsb", 1'b1, fault_status_n_o)
        rdr(4'h4);
        `CHK("sticky", 1'b1, rd[0])
        rdr(4'h4);
        `CHK("cleared", 1'b0, rd[0])
        @(posedge clk_i);
        oc <= 2'b01;
        lat <= 2'b01;
        wm(MODE_FAULT, 5);
        @(posedge clk_i);
        oc <= 2'b00;
        wm(MODE_NORMAL, 5);
        rdr(4'h4);
        rdr(4'h4);
        `CHK("latched", 1'b1, rd[0])
        @(posedge clk_i);
        lat <= 2'b00;
        rdr(4'h4);
        rdr(4'h4);
        `CHK("unlatched", 1'b0, rd[0])
        @(posedge clk_i);
        ov <= 1'b1;
        wm(MODE_FAULT, 5);
        `CHK("ov off", 2'b00, channel_on_o)
        @(posedge clk_i);
        ov <= 1'b0;
        wm(MODE_NORMAL, 5);
        @(posedge clk_i);
        ck <= 1'b1;
        wm(MODE_FAULT, 5);
        `CHK("ck on", 2'b01, channel_on_o)
        @(posedge clk_i);
        ck <= 1'b0;
        wm(MODE_NORMAL, 5);
        $display("test fault done");
        i_mcu.pins(1'b0, 2'b00);
        wm(MODE_SLEEP, 60);
        `CHK("sl ch", 2'b00, channel_on_o)
        i_mcu.pins(1'b0, 2'b01);
        wm(MODE_NORMAL, 5);
        cyc(2);
        `CHK("dir ch", 2'b01, channel_on_o)
        i_mcu.pins(1'b0, 2'b00);
        cyc(30);
        `CHK("idle", MODE_NORMAL, mode_o)
        wm(MODE_SLEEP, 30);
        $display("test idle done");
        `CHK("delatch", 2, dl_cnt)
        finish_test();
    end
endmodule : tb_top
